// >>> hdl/storm_if.sv
// Interface joining the register bank to the per-port storm meter.
// Assumes one clock domain shared by both ends.
`timescale 1ns/100ps
interface storm_if;
  logic [10:0] limit;
  logic        speed_10;
  logic [4:0]  bcast_block;
  logic [4:0]  port_drop;
  modport bank  (output limit, output speed_10, output bcast_block, input port_drop);
  modport meter (input limit, input speed_10, input bcast_block, output port_drop);
endinterface

// >>> hdl/storm_meter.sv
// Broadcast storm meter: per-port 64-byte block counts within a timed interval.
// Assumes one pulse on bcast_block per broadcast 64-byte block received.
`timescale 1ns/100ps
module storm_meter #(
  parameter int INTV_100 = swctl_pkg::INTV_100_CYC,
  parameter int INTV_10  = swctl_pkg::INTV_10_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  storm_if.meter   sif
);
  logic [28:0] tick_reg, tick_next;
  logic [10:0] cnt_reg [swctl_pkg::NPORTS];
  logic [10:0] cnt_next [swctl_pkg::NPORTS];
  logic [4:0]  drop_reg, drop_next;
  logic        wrap;

  always_comb begin
    // Interval length follows the switch speed; a change takes effect at once in the wrap compare
    wrap      = sif.speed_10 ? (tick_reg >= 29'(INTV_10 - 1))
                             : (tick_reg >= 29'(INTV_100 - 1));
    tick_next = wrap ? 29'h0 : tick_reg + 29'h1;
    for (int p = 0; p < swctl_pkg::NPORTS; p++) begin
      cnt_next[p]  = cnt_reg[p];
      drop_next[p] = drop_reg[p];
      if (wrap) begin
        cnt_next[p]  = 11'h0;
        drop_next[p] = 1'b0;
      end else if (sif.bcast_block[p] && !drop_reg[p]) begin
        cnt_next[p] = cnt_reg[p] + 11'h1;
        if (cnt_reg[p] + 11'h1 >= sif.limit)
          drop_next[p] = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tick_reg <= 29'h0;
      drop_reg <= 5'h0;
      for (int p = 0; p < swctl_pkg::NPORTS; p++)
        cnt_reg[p] <= 11'h0;
    end else begin
      tick_reg <= tick_next;
      drop_reg <= drop_next;
      cnt_reg  <= cnt_next;
    end
  end

  assign sif.port_drop = drop_reg;
endmodule // storm_meter

// >>> hdl/swctl_pkg.sv
// Package for the switch global control register bank.
// Assumes a single 100 MHz clock and a word-per-register AHB-Lite map.
// Summary of operation
// - Control bit 7 enables half-duplex back pressure on the switch MII.
// - Control bit 6 selects switch MII duplex: one half, zero full.
// - Duplex bit resets to the duplex strap level; low means full duplex.
// - Control bit 5 enables full-duplex flow control on the switch MII.
// - Flow control bit resets to the flow control strap level.
// - Control bit 4 selects speed: one is 10Mbps, zero is 100Mbps.
// - Speed bit resets to the speed strap level; high means 10 megabit.
// - Control bit 3 replaces a null VLAN ID with the port VLAN ID.
// - Storm limit is 11 bits: [10:8] in control, [7:0] in next register.
// - Storm limit counts 64-byte blocks per input port per interval.
// - Interval is 50 ms at 100 megabit and 500 ms at 10 megabit.
// - Storm limit resets to 0x4a with upper bits 000.
// - Three factory-test registers reset to 0x24, 0x28, 0x24; host leaves them.
// - Indirect control bit 1 selects LED mode; default from a strap pin.
package swctl_pkg;
  // Register index; the link control word takes index 6 so it does not share 7
  localparam logic [5:0]  IDX_LINK_CTRL  = 6'h06;
  localparam logic [5:0]  IDX_STORM_LOW  = 6'h07;
  localparam logic [5:0]  IDX_FTEST_A    = 6'h08;
  localparam logic [5:0]  IDX_FTEST_B    = 6'h09;
  localparam logic [5:0]  IDX_FTEST_C    = 6'h0a;
  localparam logic [5:0]  IDX_IND_CTRL   = 6'h0b;
  localparam logic [5:0]  IDX_STORM_STAT = 6'h0c;
  // Byte address is four times the register index
  localparam logic [7:0]  OFS_LINK_CTRL  = {IDX_LINK_CTRL, 2'b00};
  localparam logic [7:0]  OFS_STORM_LOW  = {IDX_STORM_LOW, 2'b00};
  localparam logic [7:0]  OFS_FTEST_A    = {IDX_FTEST_A, 2'b00};
  localparam logic [7:0]  OFS_FTEST_B    = {IDX_FTEST_B, 2'b00};
  localparam logic [7:0]  OFS_FTEST_C    = {IDX_FTEST_C, 2'b00};
  localparam logic [7:0]  OFS_IND_CTRL   = {IDX_IND_CTRL, 2'b00};
  localparam logic [7:0]  OFS_STORM_STAT = {IDX_STORM_STAT, 2'b00};
  localparam int          BIT_BACKPRESS  = 7;
  localparam int          BIT_HALF_DUP   = 6;
  localparam int          BIT_FLOW_CTRL  = 5;
  localparam int          BIT_SPEED_10   = 4;
  localparam int          BIT_VID_SUBST  = 3;
  localparam int          BIT_LED_MODE   = 1;
  localparam int          BIT_TEST_PWR   = 0;
  localparam int          BIT_FACT_SET   = 2;
  localparam logic [7:0]  RST_LINK_CTRL  = 8'h00;
  localparam logic [7:0]  RST_STORM_LOW  = 8'h4a;
  localparam logic [7:0]  RST_FTEST_A    = 8'h24;
  localparam logic [7:0]  RST_FTEST_B    = 8'h28;
  localparam logic [7:0]  RST_FTEST_C    = 8'h24;
  localparam logic [7:0]  RST_IND_CTRL   = 8'h00;
  localparam logic [7:0]  IND_WR_MASK    = 8'h07;
  localparam int          BLOCK_BYTES    = 64;
  localparam int          CLK_MHZ        = 100;
  localparam int          INTV_100_MS    = 50;
  localparam int          INTV_10_MS     = 500;
  localparam int          INTV_100_CYC   = INTV_100_MS * 1000 * CLK_MHZ;
  localparam int          INTV_10_CYC    = INTV_10_MS * 1000 * CLK_MHZ;
  localparam int          NPORTS         = 5;
endpackage

// >>> hdl/switch_global_ctrl_storm_led.sv
// Global switch control register bank with storm meter and LED mapping.
// Assumes an AHB-Lite master, synchronous strap and port status inputs.
`timescale 1ns/100ps
module switch_global_ctrl_storm_led #(
  parameter int INTV_100 = swctl_pkg::INTV_100_CYC,
  parameter int INTV_10  = swctl_pkg::INTV_10_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        duplex_strap_pin,
  input  wire logic        flow_ctrl_strap_pin,
  input  wire logic        speed_strap_pin,
  input  wire logic        led_mode_strap_pin,
  input  wire logic [4:0]  bcast_block,
  input  wire logic        link_up,
  input  wire logic        activity,
  input  wire logic        collision,
  input  wire logic        null_vid,
  input  wire logic [11:0] frame_vid,
  input  wire logic [11:0] port_vid,
  output logic             mii_backpressure_en,
  output logic             mii_half_duplex,
  output logic             mii_flow_ctrl_en,
  output logic             mii_speed_10,
  output logic             special_test_power_mode,
  output logic [11:0]      out_vid,
  output logic [4:0]       bcast_drop,
  output logic             port_led_two,
  output logic             port_led_one,
  output logic             port_led_zero
);
  storm_if sif ();

  logic [7:0]  link_reg, link_next;
  logic [7:0]  slow_reg, slow_next;
  logic [7:0]  fta_reg, fta_next;
  logic [7:0]  ftb_reg, ftb_next;
  logic [7:0]  ftc_reg, ftc_next;
  logic [7:0]  ind_reg, ind_next;
  logic        strap_done_reg, strap_done_next;
  logic        wpend_reg, wpend_next;
  logic [7:0]  waddr_reg, waddr_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic [7:0]  outs_reg, outs_next;
  logic [11:0] vid_reg, vid_next;
  logic [4:0]  drop_reg;
  logic [2:0]  led_reg, led_next;
  logic        aphase;

  function automatic logic [7:0] read_mux(input logic [7:0] a);
    case (a)
      swctl_pkg::OFS_LINK_CTRL:  read_mux = link_reg;
      swctl_pkg::OFS_STORM_LOW:  read_mux = slow_reg;
      swctl_pkg::OFS_FTEST_A:    read_mux = fta_reg;
      swctl_pkg::OFS_FTEST_B:    read_mux = ftb_reg;
      swctl_pkg::OFS_FTEST_C:    read_mux = ftc_reg;
      swctl_pkg::OFS_IND_CTRL:   read_mux = ind_reg;
      swctl_pkg::OFS_STORM_STAT: read_mux = {3'h0, sif.port_drop};
      default:                   read_mux = 8'h00;
    endcase
  endfunction

  assign aphase = hsel && hready && htrans[1];

  // Bus and register state
  always_comb begin
    link_next       = link_reg;
    slow_next       = slow_reg;
    fta_next        = fta_reg;
    ftb_next        = ftb_reg;
    ftc_next        = ftc_reg;
    ind_next        = ind_reg;
    strap_done_next = 1'b1;
    wpend_next      = aphase && hwrite;
    waddr_next      = aphase ? haddr[7:0] : waddr_reg;
    hrdata_next     = hrdata_reg;
    // Straps caught on the first edge after reset release only
    if (!strap_done_reg) begin
      link_next[swctl_pkg::BIT_HALF_DUP]  = duplex_strap_pin;
      link_next[swctl_pkg::BIT_FLOW_CTRL] = flow_ctrl_strap_pin;
      link_next[swctl_pkg::BIT_SPEED_10]  = speed_strap_pin;
      ind_next[swctl_pkg::BIT_LED_MODE]   = led_mode_strap_pin;
    end
    if (wpend_reg) begin
      case (waddr_reg)
        swctl_pkg::OFS_LINK_CTRL: link_next = hwdata[7:0];
        swctl_pkg::OFS_STORM_LOW: slow_next = hwdata[7:0];
        swctl_pkg::OFS_FTEST_A:   fta_next  = hwdata[7:0];
        swctl_pkg::OFS_FTEST_B:   ftb_next  = hwdata[7:0];
        swctl_pkg::OFS_FTEST_C:   ftc_next  = hwdata[7:0];
        // Upper bits of this register are read-only zero
        swctl_pkg::OFS_IND_CTRL:  ind_next  = hwdata[7:0] & swctl_pkg::IND_WR_MASK;
        default:                  ;
      endcase
    end
    // A read in the same cycle as a write completion sees the old contents
    if (aphase && !hwrite)
      hrdata_next = {24'h0, read_mux(haddr[7:0])};
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      link_reg       <= swctl_pkg::RST_LINK_CTRL;
      slow_reg       <= swctl_pkg::RST_STORM_LOW;
      fta_reg        <= swctl_pkg::RST_FTEST_A;
      ftb_reg        <= swctl_pkg::RST_FTEST_B;
      ftc_reg        <= swctl_pkg::RST_FTEST_C;
      ind_reg        <= swctl_pkg::RST_IND_CTRL;
      strap_done_reg <= 1'b0;
      wpend_reg      <= 1'b0;
      waddr_reg      <= 8'h00;
      hrdata_reg     <= 32'h0;
    end else begin
      link_reg       <= link_next;
      slow_reg       <= slow_next;
      fta_reg        <= fta_next;
      ftb_reg        <= ftb_next;
      ftc_reg        <= ftc_next;
      ind_reg        <= ind_next;
      strap_done_reg <= strap_done_next;
      wpend_reg      <= wpend_next;
      waddr_reg      <= waddr_next;
      hrdata_reg     <= hrdata_next;
    end
  end

  assign sif.limit       = {link_reg[2:0], slow_reg};
  assign sif.speed_10    = link_reg[swctl_pkg::BIT_SPEED_10];
  assign sif.bcast_block = bcast_block;

  storm_meter #(
    .INTV_100 (INTV_100),
    .INTV_10  (INTV_10)
  ) u_meter (
    .mclk  (mclk),
    .rst_n (rst_n),
    .sif   (sif)
  );

  // Datapath controls, registered so every output leaves a flip-flop
  always_comb begin
    outs_next    = 8'h00;
    outs_next[0] = link_reg[swctl_pkg::BIT_BACKPRESS];
    outs_next[1] = link_reg[swctl_pkg::BIT_HALF_DUP];
    outs_next[2] = link_reg[swctl_pkg::BIT_FLOW_CTRL];
    outs_next[3] = link_reg[swctl_pkg::BIT_SPEED_10];
    outs_next[4] = ind_reg[swctl_pkg::BIT_TEST_PWR];
    vid_next     = (link_reg[swctl_pkg::BIT_VID_SUBST] && null_vid) ? port_vid
                                                                   : frame_vid;
    // Mode 0: link/act, duplex/col, speed; mode 1: 100 link, 10 link, full duplex
    if (ind_reg[swctl_pkg::BIT_LED_MODE]) begin
      led_next[2] = link_up && !link_reg[swctl_pkg::BIT_SPEED_10] && !activity;
      led_next[1] = link_up && link_reg[swctl_pkg::BIT_SPEED_10] && !activity;
      led_next[0] = link_reg[swctl_pkg::BIT_HALF_DUP];
    end else begin
      led_next[2] = !(link_up && !activity);
      led_next[1] = link_reg[swctl_pkg::BIT_HALF_DUP] || collision;
      led_next[0] = link_reg[swctl_pkg::BIT_SPEED_10];
    end
    // LEDs are active low in mode 1 too; the pin drives the cathode
    if (ind_reg[swctl_pkg::BIT_LED_MODE]) begin
      led_next[2] = !led_next[2];
      led_next[1] = !led_next[1];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      outs_reg <= 8'h00;
      vid_reg  <= 12'h000;
      drop_reg <= 5'h00;
      led_reg  <= 3'h7;
    end else begin
      outs_reg <= outs_next;
      vid_reg  <= vid_next;
      drop_reg <= sif.port_drop;
      led_reg  <= led_next;
    end
  end

  assign hrdata                  = hrdata_reg;
  assign hreadyout               = 1'b1;
  assign hresp                   = 1'b0;
  assign mii_backpressure_en     = outs_reg[0];
  assign mii_half_duplex         = outs_reg[1];
  assign mii_flow_ctrl_en        = outs_reg[2];
  assign mii_speed_10            = outs_reg[3];
  assign special_test_power_mode = outs_reg[4];
  assign out_vid                 = vid_reg;
  assign bcast_drop              = drop_reg;
  assign port_led_two            = led_reg[2];
  assign port_led_one            = led_reg[1];
  assign port_led_zero           = led_reg[0];
endmodule // switch_global_ctrl_storm_led

// >>> tb/mac_partner.sv
// Stand-in for the external MAC: emits broadcast block pulses per port.
// Assumes the bank counts one block per single-cycle pulse.
`timescale 1ns/100ps
module mac_partner (
  input  wire logic       mclk,
  output logic      [4:0] bcast_block
);
  initial bcast_block = 5'h00;
  // An idle cycle between blocks keeps each pulse distinct
  task automatic send(input logic [4:0] ports, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      bcast_block <= ports;
      @(posedge mclk);
      bcast_block <= 5'h00;
    end
  endtask
endmodule // mac_partner

// >>> tb/swctl_checker.sv
// Checker for the switch control bank, bound to the top module ports.
// Assumes hready is fed back from hreadyout and straps hold through reset.
`timescale 1ns/100ps
module swctl_checker (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        duplex_strap_pin,
  input wire logic        flow_ctrl_strap_pin,
  input wire logic        speed_strap_pin,
  input wire logic        led_mode_strap_pin,
  input wire logic [4:0]  bcast_block,
  input wire logic        collision,
  input wire logic        link_up,
  input wire logic        activity,
  input wire logic        null_vid,
  input wire logic [11:0] frame_vid,
  input wire logic [11:0] port_vid,
  input wire logic        mii_backpressure_en,
  input wire logic        mii_half_duplex,
  input wire logic        mii_flow_ctrl_en,
  input wire logic        mii_speed_10,
  input wire logic [11:0] out_vid,
  input wire logic [4:0]  bcast_drop,
  input wire logic        port_led_two,
  input wire logic        port_led_one,
  input wire logic        port_led_zero
);
  logic       wr_ph;
  logic [7:0] wr_adr;
  logic [1:0] cnt;
  logic       ledm;
  logic       vsub;
  // Shadow of the bits the outputs depend on, tracked from bus writes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ph <= 1'b0;
      wr_adr <= 8'h00;
      cnt <= 2'h0;
      ledm <= 1'b0;
      vsub <= 1'b0;
    end else begin
      wr_ph <= hsel & hready & htrans[1] & hwrite;
      wr_adr <= haddr[7:0];
      if (cnt != 2'h3) cnt <= cnt + 2'h1;
      if (cnt == 2'h0) ledm <= led_mode_strap_pin;
      if (wr_ph && wr_adr == 8'h2c) ledm <= hwdata[1];
      if (wr_ph && wr_adr == 8'h18) vsub <= hwdata[3];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not okay");
  a_rdata_high: assert property (hrdata[31:8] == 24'h0) else $error("read data upper bits set");
  a_link_follow: assert property (wr_ph && wr_adr == 8'h18 |=> ##1
    {mii_backpressure_en, mii_half_duplex, mii_flow_ctrl_en, mii_speed_10}
    == $past(hwdata[7:4], 2)) else $error("link outputs do not follow write");
  a_strap_load: assert property (cnt == 2'h2 |-> mii_half_duplex == duplex_strap_pin
    && mii_flow_ctrl_en == flow_ctrl_strap_pin && mii_speed_10 == speed_strap_pin)
    else $error("strap levels not loaded");
  a_vid_pick: assert property (cnt == 2'h3 |->
    out_vid == $past(vsub && null_vid ? port_vid : frame_vid)) else $error("vid choice wrong");
  a_led_zero: assert property (cnt == 2'h3 |->
    port_led_zero == ($past(ledm) ? mii_half_duplex : mii_speed_10)) else $error("led zero wrong");
  a_led_one: assert property (cnt == 2'h3 && !$past(ledm) |->
    port_led_one == (mii_half_duplex | $past(collision))) else $error("led one wrong");
  a_led_two: assert property (cnt == 2'h3 && !$past(ledm) |->
    port_led_two == !($past(link_up) && !$past(activity))) else $error("led two wrong");
  a_drop_cause: assert property (
    ((bcast_drop & ~$past(bcast_drop)) & ~$past(bcast_block, 2)) == 5'h00)
    else $error("drop rose without a block");
endmodule // swctl_checker
bind switch_global_ctrl_storm_led swctl_checker chk_i (.*);

// >>> tb/switch_global_ctrl_storm_led_tb_top.sv
// Testbench for the switch control bank, driven over AHB-Lite.
// Assumes zero wait states; storm intervals are shortened by parameter.
`timescale 1ns/100ps
module switch_global_ctrl_storm_led_tb_top;
  localparam int I100 = 100;
  localparam int I10  = 1000;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [3:0]  strap = 4'b1010;
  logic        collision = 1'b0;
  logic        null_vid = 1'b0;
  logic        activity = 1'b0;
  logic        test_pwr;
  logic        led_two;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic [11:0] out_vid;
  logic [4:0]  bcast_block;
  logic [4:0]  bcast_drop;
  logic [31:0] rd;
  logic [7:0]  ra [5] = '{8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c};
  logic [7:0]  rv [5] = '{8'h4a, 8'h24, 8'h28, 8'h24, 8'h00};
  int          error_cnt = 0;
  int          num_checks = 0;
  int          n;
  int          iv;
  always #5 mclk = ~mclk;
  switch_global_ctrl_storm_led #(.INTV_100(I100), .INTV_10(I10)) dut (
    .mclk(mclk), .rst_n(rst_n), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(), .duplex_strap_pin(strap[3]),
    .flow_ctrl_strap_pin(strap[2]), .speed_strap_pin(strap[1]),
    .led_mode_strap_pin(strap[0]), .bcast_block(bcast_block), .link_up(1'b1),
    .activity(activity), .collision(collision), .null_vid(null_vid), .frame_vid(12'h123),
    .port_vid(12'habc), .mii_backpressure_en(), .mii_half_duplex(), .mii_flow_ctrl_en(),
    .mii_speed_10(), .special_test_power_mode(test_pwr), .out_vid(out_vid),
    .bcast_drop(bcast_drop), .port_led_two(led_two), .port_led_one(), .port_led_zero()
  );
  mac_partner mac (.mclk(mclk), .bcast_block(bcast_block));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Address phase held until hready, then data phase held until hready
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    rd = hrdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h00);
    chk(rd, exp);
  endtask
  task automatic waitv(input logic v);
    n = 0;
    while (bcast_drop[0] !== v && n < 1200) begin
      @(posedge mclk);
      n++;
    end
  endtask
  task automatic conclude();
    if (error_cnt == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    rdc(8'h18, 32'h50);
    for (int i = 0; i < 5; i++) rdc(ra[i], {24'h0, rv[i]});
    bus(1'b1, 8'h18, 8'hff);
    rdc(8'h18, 32'hff);
    bus(1'b1, 8'h2c, 8'hff);
    rdc(8'h2c, 32'h07);
    chk({31'h0, test_pwr}, 32'h1);
    chk({31'h0, led_two}, 32'h1);
    bus(1'b1, 8'h3c, 8'h5a);
    rdc(8'h3c, 32'h0);
    bus(1'b1, 8'h2c, 8'h00);
    repeat (2) @(posedge mclk);
    chk({31'h0, test_pwr}, 32'h0);
    chk({31'h0, led_two}, 32'h0);
    activity <= 1'b1;
    repeat (2) @(posedge mclk);
    chk({31'h0, led_two}, 32'h1);
    activity <= 1'b0;
    collision <= 1'b1;
    null_vid <= 1'b1;
    bus(1'b1, 8'h18, 8'h08);
    repeat (2) @(posedge mclk);
    chk({20'h0, out_vid}, 32'habc);
    bus(1'b1, 8'h18, 8'h00);
    repeat (2) @(posedge mclk);
    chk({20'h0, out_vid}, 32'h123);
    bus(1'b1, 8'h1c, 8'h03);
    for (int s = 0; s < 2; s++) begin
      iv = s ? I10 : I100;
      bus(1'b1, 8'h18, s ? 8'h10 : 8'h00);
      n = 0;
      // Reach the limit once so the next clear marks an interval start
      while (bcast_drop[0] !== 1'b1 && n < 50) begin
        mac.send(5'h01, 1);
        n++;
      end
      waitv(1'b0);
      mac.send(5'h1f, 2);
      repeat (3) @(posedge mclk);
      chk({27'h0, bcast_drop}, 32'h0);
      mac.send(5'h01, 1);
      repeat (3) @(posedge mclk);
      chk({27'h0, bcast_drop}, 32'h1);
      rdc(8'h30, 32'h01);
      waitv(1'b0);
      chk({31'h0, n > iv - 30 && n <= iv}, 32'h1);
    end
    rst_n <= 1'b0;
    strap <= 4'b0101;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    rdc(8'h18, 32'h20);
    rdc(8'h2c, 32'h02);
    conclude();
  end
  initial begin
    #100us;
    error_cnt++;
    conclude();
  end
endmodule // switch_global_ctrl_storm_led_tb_top
